// [design/ogma_top.sv]
// Glyph memory address generator for the on-screen display engine.
// Assumes the core writes the pointer bytes on the same clock and that the
// extended RAM answers each read with a one-cycle acknowledge carrying the byte.
// Summary of operation
// [R1] All glyph data and pointer arrays are fetched from extended RAM only.
// [R2] Four pointer bytes locate two pointer arrays in extended RAM.
// [R3] Bytes at base locate array zero; bytes at base plus two, array one.
// [R4] Two-bit mode: four pixels a byte, bit7 is pixel zero bit zero.
// [R5] Two-bit mode: three bytes a line; eleven lines give glyph stride 21h.
// [R6] Four-bit mode: two pixels a byte, upper nibble first, bit zero at bit7.
// [R7] Four-bit mode: six bytes a line; eleven lines give glyph stride 42h.
// [R8] Every glyph starts at a fresh byte; spare trailing nibbles are skipped.
// [R9] Array pointers are two bytes, low first; glyph areas at 0, 2, 4.
// [R10] Address is area pointer plus index times glyph size plus byte offset.
`timescale 1ns/100ps
`default_nettype none
module ogma_top
	import ogma_pkg::*;
#(
	parameter int ADDR_W = 16
)
(
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	// Special-function pointer port from the core.
	input wire logic I_SFR_WR,
	input wire logic I_SFR_RD,
	input wire logic [1:0] I_SFR_ADDR,
	input wire logic [7:0] I_SFR_WDATA,
	output logic [7:0] O_SFR_RDATA,
	// Glyph requests from the pixel pipeline.
	input wire logic I_REQ_VALID,
	input wire ogma_req_t I_REQ,
	output logic O_REQ_READY,
	output logic O_PIX_VALID,
	output ogma_pix_t O_PIX,
	output logic [ADDR_W-1:0] O_GLYPH_ADDR,
	// Extended RAM read port.
	output logic O_EXTENDED_RAM_RD,
	output logic [ADDR_W-1:0] O_EXTENDED_RAM_ADDR,
	input wire logic I_EXTENDED_RAM_ACK,
	input wire logic [7:0] I_EXTENDED_RAM_RDATA
);

	// Fetch sequence, Gray coded along the usual path.
	typedef enum logic [2:0]
	{
		OGMA_ST_IDLE = 3'b000,
		OGMA_ST_PTR_REQ = 3'b001,
		OGMA_ST_PTR_LO = 3'b011,
		OGMA_ST_PTR_HI = 3'b010,
		OGMA_ST_DATA = 3'b110,
		OGMA_ST_DONE = 3'b100
	} ogma_state_t;

	// Glyph byte address from area pointer, request and resolution.
	function automatic logic [ADDR_W-1:0] glyph_addr(input logic [15:0] area,
		input ogma_req_t req);
		logic [15:0] bpp;
		logic [15:0] glyph_bytes;
		logic [15:0] bit_off;
		bpp = (req.mode == OGMA_MODE_4BIT) ? 16'h0004 :
			(req.mode == OGMA_MODE_2BIT) ? 16'h0002 : 16'h0001;
		// Round the glyph up to whole bytes so the next glyph starts fresh.
		glyph_bytes = (16'(req.line_count) * OGMA_PIX_PER_LINE * bpp
			+ OGMA_BITS_PER_BYTE - 16'h0001) / OGMA_BITS_PER_BYTE; // [R5] [R7] [R8]
		bit_off = (16'(req.line) * OGMA_PIX_PER_LINE + 16'(req.pixel)) * bpp;
		glyph_addr = ADDR_W'(area + 16'(req.index) * glyph_bytes
			+ bit_off / OGMA_BITS_PER_BYTE); // [R10]
	endfunction

	// Pointer array locations held in the special-function bytes.
	logic [15:0] arr0_loc;
	logic [15:0] arr1_loc;
	logic [15:0] next_arr0_loc;
	logic [15:0] next_arr1_loc;
	logic [7:0] sfr_rdata;
	logic [7:0] next_sfr_rdata;

	// Fetch state.
	ogma_state_t state;
	ogma_state_t next_state;
	ogma_req_t req;
	ogma_req_t next_req;
	logic [15:0] area;
	logic [15:0] next_area;
	logic extended_ram_rd;
	logic next_extended_ram_rd;
	logic [ADDR_W-1:0] extended_ram_addr;
	logic [ADDR_W-1:0] next_extended_ram_addr;
	logic [ADDR_W-1:0] glyph_byte_addr;
	logic [ADDR_W-1:0] next_glyph_byte_addr;
	logic pix_valid;
	logic next_pix_valid;
	ogma_pix_t pix;
	ogma_pix_t next_pix;
	ogma_pix_t unpacked;
	logic [15:0] arr1_slot;
	logic req_ready;

	// Pixel unpacking of the byte arriving from extended RAM.
	ogma_unpack i_ogma_unpack
	(
		.i_mode(req.mode),
		.i_byte(I_EXTENDED_RAM_RDATA),
		.o_pix(unpacked)
	);

	// Pointer byte writes and read-back.
	always_comb
	begin
		next_arr0_loc = arr0_loc;
		next_arr1_loc = arr1_loc;
		next_sfr_rdata = sfr_rdata;
		if (I_SFR_WR)
		begin
			case (I_SFR_ADDR) // [R2] [R3]
				OGMA_SFR_ARR0_LO: next_arr0_loc[7:0] = I_SFR_WDATA;
				OGMA_SFR_ARR0_HI: next_arr0_loc[15:8] = I_SFR_WDATA;
				OGMA_SFR_ARR1_LO: next_arr1_loc[7:0] = I_SFR_WDATA;
				OGMA_SFR_ARR1_HI: next_arr1_loc[15:8] = I_SFR_WDATA;
				default: next_arr0_loc = arr0_loc;
			endcase
		end
		if (I_SFR_RD)
		begin
			case (I_SFR_ADDR)
				OGMA_SFR_ARR0_LO: next_sfr_rdata = arr0_loc[7:0];
				OGMA_SFR_ARR0_HI: next_sfr_rdata = arr0_loc[15:8];
				OGMA_SFR_ARR1_LO: next_sfr_rdata = arr1_loc[7:0];
				OGMA_SFR_ARR1_HI: next_sfr_rdata = arr1_loc[15:8];
				default: next_sfr_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			arr0_loc <= OGMA_PTR_RESET;
			arr1_loc <= OGMA_PTR_RESET;
			sfr_rdata <= 8'h00;
		end
		else
		begin
			arr0_loc <= next_arr0_loc;
			arr1_loc <= next_arr1_loc;
			sfr_rdata <= next_sfr_rdata;
		end
	end

	// Slot in pointer array one that holds the area pointer for this mode.
	always_comb
	begin
		case (req.mode) // [R9]
			OGMA_MODE_2BIT: arr1_slot = OGMA_ARR1_TWO_BIT;
			OGMA_MODE_4BIT: arr1_slot = OGMA_ARR1_FOUR_BIT;
			default: arr1_slot = OGMA_ARR1_ONE_BIT;
		endcase
	end

	// Two-level fetch: area pointer low byte, high byte, then the glyph byte.
	always_comb
	begin
		next_state = state;
		next_req = req;
		next_area = area;
		next_extended_ram_rd = 1'b0;
		next_extended_ram_addr = extended_ram_addr;
		next_glyph_byte_addr = glyph_byte_addr;
		next_pix_valid = 1'b0;
		next_pix = pix;
		case (state)
			OGMA_ST_IDLE:
			begin
				// A request is only taken while ready is shown, never in the cycle after reset.
				if (I_REQ_VALID && req_ready)
				begin
					next_req = I_REQ;
					next_state = OGMA_ST_PTR_REQ;
				end
			end
			OGMA_ST_PTR_REQ:
			begin
				// One read pulse for the low byte of this mode's area pointer.
				next_extended_ram_rd = 1'b1;
				next_extended_ram_addr = ADDR_W'(arr1_loc + arr1_slot); // [R1] [R3] [R9]
				next_state = OGMA_ST_PTR_LO;
			end
			OGMA_ST_PTR_LO:
			begin
				// Wait for the answer to the single read pulse.
				if (I_EXTENDED_RAM_ACK)
				begin
					next_area[7:0] = I_EXTENDED_RAM_RDATA; // [R9]
					next_extended_ram_rd = 1'b1;
					next_extended_ram_addr = ADDR_W'(arr1_loc + arr1_slot + 16'h0001);
					next_state = OGMA_ST_PTR_HI;
				end
			end
			OGMA_ST_PTR_HI:
			begin
				if (I_EXTENDED_RAM_ACK)
				begin
					next_area[15:8] = I_EXTENDED_RAM_RDATA; // [R9]
					next_glyph_byte_addr = glyph_addr({I_EXTENDED_RAM_RDATA, area[7:0]}, req);
					next_extended_ram_rd = 1'b1;
					next_extended_ram_addr = glyph_addr({I_EXTENDED_RAM_RDATA, area[7:0]}, req); // [R1] [R10]
					next_state = OGMA_ST_DATA;
				end
			end
			OGMA_ST_DATA:
			begin
				if (I_EXTENDED_RAM_ACK)
				begin
					next_pix = unpacked; // [R4] [R6]
					next_pix_valid = 1'b1;
					next_state = OGMA_ST_DONE;
				end
			end
			OGMA_ST_DONE:
			begin
				next_state = OGMA_ST_IDLE;
			end
			default:
			begin
				next_state = OGMA_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			state <= OGMA_ST_IDLE;
			req <= '0;
			area <= 16'h0000;
			extended_ram_rd <= 1'b0;
			extended_ram_addr <= '1;
			glyph_byte_addr <= '0;
			pix_valid <= 1'b0;
			pix <= '0;
		end
		else
		begin
			state <= next_state;
			req <= next_req;
			area <= next_area;
			extended_ram_rd <= next_extended_ram_rd;
			extended_ram_addr <= next_extended_ram_addr;
			glyph_byte_addr <= next_glyph_byte_addr;
			pix_valid <= next_pix_valid;
			pix <= next_pix;
		end
	end

	// Ready is registered from the next state: high in every idle cycle but the first after reset, including the one that takes a request.
	always_ff @(posedge I_MCLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			req_ready <= 1'b0;
		end
		else
		begin
			req_ready <= (next_state == OGMA_ST_IDLE);
		end
	end

	// Outputs straight from flip-flops.
	assign O_SFR_RDATA = sfr_rdata;
	assign O_REQ_READY = req_ready;
	assign O_PIX_VALID = pix_valid;
	assign O_PIX = pix;
	assign O_GLYPH_ADDR = glyph_byte_addr;
	assign O_EXTENDED_RAM_RD = extended_ram_rd;
	assign O_EXTENDED_RAM_ADDR = extended_ram_addr;

endmodule
`default_nettype wire

// [design/ogma_pkg.sv]
// Package for the on-screen display glyph memory addressing block.
// Assumes one system clock and an extended RAM with a byte-wide read port.
package ogma_pkg;

	// Byte offsets of the special-function pointer bytes above their base address.
	localparam logic [1:0] OGMA_SFR_ARR0_LO = 2'h0;
	localparam logic [1:0] OGMA_SFR_ARR0_HI = 2'h1;
	localparam logic [1:0] OGMA_SFR_ARR1_LO = 2'h2;
	localparam logic [1:0] OGMA_SFR_ARR1_HI = 2'h3;

	// Reset value of both pointer array locations.
	localparam logic [15:0] OGMA_PTR_RESET = 16'h0000;

	// Byte offsets of the glyph area pointers inside pointer array one.
	localparam logic [15:0] OGMA_ARR1_ONE_BIT = 16'h0000;
	localparam logic [15:0] OGMA_ARR1_TWO_BIT = 16'h0002;
	localparam logic [15:0] OGMA_ARR1_FOUR_BIT = 16'h0004;

	// Pixels in one glyph line and bits in one byte.
	localparam logic [15:0] OGMA_PIX_PER_LINE = 16'h000C;
	localparam logic [15:0] OGMA_BITS_PER_BYTE = 16'h0008;

	// Glyph colour resolutions.
	typedef enum logic [1:0]
	{
		OGMA_MODE_1BIT = 2'h0,
		OGMA_MODE_2BIT = 2'h1,
		OGMA_MODE_4BIT = 2'h2
	} ogma_mode_t;

	// One glyph fetch request from the pixel pipeline.
	typedef struct packed
	{
		ogma_mode_t mode;
		logic [7:0] index;
		logic [3:0] line_count;
		logic [3:0] line;
		logic [3:0] pixel;
	} ogma_req_t;

	// Unpacked glyph byte: up to eight pixel values in byte order, leftmost first.
	typedef struct packed
	{
		logic [7:0] raw;
		logic [3:0] count;
		logic [7:0][3:0] pix;
	} ogma_pix_t;

endpackage

// [design/ogma_unpack.sv]
// Glyph byte unpacker: splits one extended RAM byte into pixel values.
// Assumes the mode is stable while the byte is presented; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module ogma_unpack
	import ogma_pkg::*;
(
	// Byte and resolution in.
	input wire ogma_mode_t i_mode,
	input wire logic [7:0] i_byte,
	// Pixels out.
	output ogma_pix_t o_pix
);

	// Lane k holds the k-th pixel from the left; a pixel's bit zero sits highest.
	always_comb
	begin
		o_pix = '0;
		o_pix.raw = i_byte;
		case (i_mode)
			OGMA_MODE_1BIT:
			begin
				o_pix.count = 4'h8;
				for (int k = 0; k < 8; k++)
				begin
					o_pix.pix[k] = {3'h0, i_byte[7 - k]};
				end
			end
			OGMA_MODE_2BIT:
			begin
				o_pix.count = 4'h4;
				for (int k = 0; k < 4; k++)
				begin
					o_pix.pix[k] = {2'h0, i_byte[6 - 2 * k], i_byte[7 - 2 * k]}; // [R4]
				end
			end
			OGMA_MODE_4BIT:
			begin
				o_pix.count = 4'h2;
				for (int k = 0; k < 2; k++)
				begin
					o_pix.pix[k] = {i_byte[4 - 4 * k], i_byte[5 - 4 * k],
						i_byte[6 - 4 * k], i_byte[7 - 4 * k]}; // [R6]
				end
			end
			default:
			begin
				o_pix.count = 4'h0;
			end
		endcase
	end

endmodule
`default_nettype wire

// [verification/ogma_chk.sv]
// Checker for the glyph address generator: fetch timing and pixel packing.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/100ps
`default_nettype none
module ogma_chk
	import ogma_pkg::*;
#(
	parameter int ADDR_W = 16
)
(
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	// Request side.
	input wire logic I_REQ_VALID,
	input wire logic O_REQ_READY,
	input wire logic O_PIX_VALID,
	input wire ogma_pix_t O_PIX,
	input wire logic [ADDR_W-1:0] O_GLYPH_ADDR,
	// Extended RAM side.
	input wire logic O_EXTENDED_RAM_RD,
	input wire logic [ADDR_W-1:0] O_EXTENDED_RAM_ADDR,
	input wire logic I_EXTENDED_RAM_ACK,
	input wire logic [7:0] I_EXTENDED_RAM_RDATA
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);
	// A taken request drops ready and is answered in bounded time.
	a_take_busy: assert property (I_REQ_VALID && O_REQ_READY |=> !O_REQ_READY)
		else $error("ready stayed high after a take");
	a_answer_bound: assert property (I_REQ_VALID && O_REQ_READY |-> ##[6:200] O_PIX_VALID)
		else $error("no answer within bound");
	// Reads are single pulses and only happen while busy.
	a_rd_pulse: assert property (O_EXTENDED_RAM_RD |=> !O_EXTENDED_RAM_RD)
		else $error("read pulse too long");
	a_idle_quiet: assert property (O_REQ_READY |-> !O_EXTENDED_RAM_RD && !O_PIX_VALID)
		else $error("activity while idle");
	// The answer is one pulse carrying the byte read at the glyph address.
	a_pix_pulse: assert property (O_PIX_VALID |=> !O_PIX_VALID)
		else $error("answer pulse too long");
	a_pix_source: assert property (O_PIX_VALID |->
		$past(I_EXTENDED_RAM_ACK) && O_PIX.raw == $past(I_EXTENDED_RAM_RDATA)) else $error("byte not from RAM");
	a_glyph_addr: assert property (O_PIX_VALID |-> O_EXTENDED_RAM_ADDR == O_GLYPH_ADDR)
		else $error("last read not at glyph address");
	// Rightmost pixels of a byte sit in the low bits, bit zero highest.
	a_two_bit: assert property (O_PIX_VALID && O_PIX.count == 4'h4 |->
		O_PIX.pix[3][1:0] == {O_PIX.raw[0], O_PIX.raw[1]}) else $error("two bit packing");
	a_four_bit: assert property (O_PIX_VALID && O_PIX.count == 4'h2 |->
		O_PIX.pix[1] == {O_PIX.raw[0], O_PIX.raw[1], O_PIX.raw[2], O_PIX.raw[3]})
		else $error("four bit packing");
	// Each resolution is answered at least once.
	c_one_bit: cover property (O_PIX_VALID && O_PIX.count == 4'h8);
	c_two_bit: cover property (O_PIX_VALID && O_PIX.count == 4'h4);
	c_four_bit: cover property (O_PIX_VALID && O_PIX.count == 4'h2);
endmodule
bind ogma_top ogma_chk #(.ADDR_W(ADDR_W)) i_ogma_chk (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B),
	.I_REQ_VALID(I_REQ_VALID), .O_REQ_READY(O_REQ_READY), .O_PIX_VALID(O_PIX_VALID),
	.O_PIX(O_PIX), .O_GLYPH_ADDR(O_GLYPH_ADDR), .O_EXTENDED_RAM_RD(O_EXTENDED_RAM_RD),
	.O_EXTENDED_RAM_ADDR(O_EXTENDED_RAM_ADDR), .I_EXTENDED_RAM_ACK(I_EXTENDED_RAM_ACK), .I_EXTENDED_RAM_RDATA(I_EXTENDED_RAM_RDATA));
`default_nettype wire

// [verification/ogma_ram.sv]
// Extended RAM model behind the glyph read port.
// Answers each read after dly spare cycles; between answers the data line toggles.
`timescale 1ns/100ps
`default_nettype none
module ogma_ram
(
	// Clock.
	input wire logic i_clk,
	// Read port.
	input wire logic i_rd,
	input wire logic [15:0] i_addr,
	output logic o_ack,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr;
	int dly = 0;
	int cnt = 0;
	// Start quiet so the first answer is not mistaken for an unknown pulse.
	initial
	begin
		o_ack = 1'h0;
		o_rdata = 8'h00;
	end
	// Latch the address on a read and count the spare cycles down.
	always @(posedge i_clk)
	begin
		if (i_rd)
		begin
			addr <= i_addr;
			cnt <= dly;
		end
		else if (cnt > 0)
		begin
			cnt <= cnt - 1;
		end
	end
	// Answer once when the count runs out; otherwise the data line inverts its last byte every cycle.
	always @(posedge i_clk)
	begin
		if ((i_rd && dly == 0) || (!i_rd && cnt == 1))
		begin
			o_ack <= 1'h1;
			o_rdata <= mem[i_rd ? i_addr : addr];
		end
		else
		begin
			o_ack <= 1'h0;
			o_rdata <= ~o_rdata;
		end
	end
endmodule
`default_nettype wire

// [verification/ogma_top_bench.sv]
// Testbench for the glyph address generator: pointer setup and glyph fetches.
// Assumes the RAM model is preloaded here through its array.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module ogma_top_bench
	import ogma_pkg::*;
;
	logic clk, rst_b, w_en, r_en, req_valid, req_ready, pix_valid, extended_ram_rd, extended_ram_ack;
	logic [1:0] sfr_addr;
	logic [7:0] sfr_wdata, sfr_rdata, extended_ram_rdata;
	logic [15:0] glyph_addr, extended_ram_addr;
	ogma_req_t req;
	ogma_pix_t pix;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;
	// Design and RAM model.
	ogma_top #(.ADDR_W(16)) i_ogma_top (.I_MCLK(clk), .I_RST_B(rst_b), .I_SFR_WR(w_en),
		.I_SFR_RD(r_en), .I_SFR_ADDR(sfr_addr), .I_SFR_WDATA(sfr_wdata),
		.O_SFR_RDATA(sfr_rdata), .I_REQ_VALID(req_valid), .I_REQ(req), .O_REQ_READY(req_ready),
		.O_PIX_VALID(pix_valid), .O_PIX(pix), .O_GLYPH_ADDR(glyph_addr), .O_EXTENDED_RAM_RD(extended_ram_rd),
		.O_EXTENDED_RAM_ADDR(extended_ram_addr), .I_EXTENDED_RAM_ACK(extended_ram_ack), .I_EXTENDED_RAM_RDATA(extended_ram_rdata));
	ogma_ram i_ogma_ram (.i_clk(clk), .i_rd(extended_ram_rd), .i_addr(extended_ram_addr), .o_ack(extended_ram_ack),
		.o_rdata(extended_ram_rdata));
	// Clock at 8 ns and a ceiling that cuts a hang short.
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			conclude();
		end
	end
	// Print the counts and the verdict, then stop.
	task automatic conclude();
	begin
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	// Write a pointer location, low then high byte on consecutive cycles.
	task automatic put_ptr(input logic [1:0] a, input logic [15:0] d);
	begin
		@(negedge clk);
		w_en = 1'h1;
		sfr_addr = a;
		sfr_wdata = d[7:0];
		@(negedge clk);
		sfr_addr = a + 2'h1;
		sfr_wdata = d[15:8];
		@(negedge clk);
		w_en = 1'h0;
	end
	endtask
	// Read a pointer location back with two back-to-back reads.
	task automatic get_ptr(input logic [1:0] a, input logic [15:0] e);
		logic [7:0] lo;
	begin
		@(negedge clk);
		r_en = 1'h1;
		sfr_addr = a;
		@(negedge clk);
		lo = sfr_rdata;
		sfr_addr = a + 2'h1;
		@(negedge clk);
		r_en = 1'h0;
		`CHK("pointer", e, {sfr_rdata, lo})
	end
	endtask
	// Fetch one glyph byte; compare address and byte, plus count, leftmost and last pixel in two- and four-bit modes.
	task automatic fetch(input ogma_mode_t m, input logic [7:0] idx, input logic [3:0] lc,
		input logic [3:0] ln, input logic [3:0] px, input logic [15:0] ea);
		int n;
		logic [7:0] raw;
	begin
		raw = ea[7:0] ^ ea[15:8] ^ 8'h5A;
		@(negedge clk);
		req = '{m, idx, lc, ln, px};
		req_valid = 1'h1;
		for (n = 0; n < 50 && req_ready !== 1'h1; n++)
			@(negedge clk);
		@(negedge clk);
		req_valid = 1'h0;
		for (n = 0; n < 99 && pix_valid !== 1'h1; n++)
			@(negedge clk);
		`CHK("answer", 1'h1, pix_valid)
		`CHK("glyph address", ea, glyph_addr)
		`CHK("glyph byte", raw, pix.raw)
		if (m == OGMA_MODE_2BIT)
		begin
			`CHK("two bit count", 4'h4, pix.count)
			`CHK("two bit pixel", {raw[6], raw[7]}, pix.pix[0][1:0])
			`CHK("two bit last pixel", {raw[0], raw[1]}, pix.pix[3][1:0])
		end
		else if (m == OGMA_MODE_4BIT)
		begin
			`CHK("four bit count", 4'h2, pix.count)
			`CHK("four bit pixel", {raw[4], raw[5], raw[6], raw[7]}, pix.pix[0])
			`CHK("four bit last pixel", {raw[0], raw[1], raw[2], raw[3]}, pix.pix[1])
		end
	end
	endtask
	// Reset, pointer checks, then the glyph table with prompt and slow RAM.
	initial
	begin
		rst_b = 1'h0;
		w_en = 1'h0;
		r_en = 1'h0;
		sfr_addr = 2'h0;
		sfr_wdata = 8'h00;
		req_valid = 1'h0;
		req = '0;
		for (int a = 0; a < 65536; a++)
			i_ogma_ram.mem[a] = a[7:0] ^ a[15:8] ^ 8'h5A;
		{i_ogma_ram.mem[16'h1005], i_ogma_ram.mem[16'h1004], i_ogma_ram.mem[16'h1003],
			i_ogma_ram.mem[16'h1002], i_ogma_ram.mem[16'h1001],
			i_ogma_ram.mem[16'h1000]} = 48'h400030002000;
		repeat (10) @(negedge clk);
		`CHK("reset address", 16'hFFFF, extended_ram_addr)
		rst_b = 1'h1;
		get_ptr(2'h0, 16'h0000);
		get_ptr(2'h2, 16'h0000);
		$display("test reset done");
		put_ptr(2'h0, 16'hBEEF);
		put_ptr(2'h2, 16'h1000);
		get_ptr(2'h0, 16'hBEEF);
		get_ptr(2'h2, 16'h1000);
		$display("test pointers done");
		for (int d = 0; d < 3; d += 2)
		begin
			i_ogma_ram.dly = d;
			fetch(OGMA_MODE_2BIT, 8'h01, 4'hB, 4'h0, 4'h0, 16'h3021);
			fetch(OGMA_MODE_2BIT, 8'h00, 4'hB, 4'hA, 4'h8, 16'h3020);
			fetch(OGMA_MODE_4BIT, 8'h01, 4'hB, 4'h0, 4'h0, 16'h4042);
			fetch(OGMA_MODE_4BIT, 8'h00, 4'hB, 4'hA, 4'hA, 16'h4041);
			fetch(OGMA_MODE_1BIT, 8'h01, 4'hB, 4'h0, 4'h0, 16'h2011);
			fetch(OGMA_MODE_4BIT, 8'h03, 4'h1, 4'h0, 4'h2, 16'h4013);
			fetch(OGMA_MODE_2BIT, 8'h02, 4'h3, 4'h2, 4'h5, 16'h3019);
			$display("test fetch with delay %0d done", d);
		end
		conclude();
	end
endmodule
`default_nettype wire
